/* File: src/ebt_consts.vh */
// constants for the eight-bit reload timer
`ifndef EBT_CONSTS_VH
`define EBT_CONSTS_VH
`define EBT_ADDR_W 2
`define EBT_ADDR_MODE 2'h0
`define EBT_ADDR_COUNT 2'h1
`define EBT_ADDR_IRQ 2'h2
`define EBT_ADDR_PORT 2'h3
`define EBT_MODE_BIT 7
`define EBT_CKS_HI 2
`define EBT_CKS_LO 0
`define EBT_CKS_EXT 3'h7
`define EBT_RSVD_ONES 8'h78
`define EBT_MODE_RST 8'h00
`define EBT_COUNT_RST 8'h00
`define EBT_RELOAD_RST 8'h00
`define EBT_COUNT_MAX 8'hFF
`define EBT_IRQ_FLAG_BIT 0
`define EBT_IRQ_EN_BIT 1
`define EBT_IRQ_EDGE_BIT 2
`define EBT_PORT_FUNC_BIT 0
`define EBT_PRE_W 13
`define EBT_PRE_ZERO 13'h0000
`define EBT_PRE_ONE 13'h0001
`define EBT_BYTE_ZERO 8'h00
`endif

/* File: src/ebt_prescaler.v */
// free-running prescaler giving one-cycle ticks for the seven divided clocks
module ebt_prescaler (
  // clock and reset
  input wire i_clk_sys,
  input wire i_nrst,
  // selection
  input wire [2:0] i_sel,
  // tick out
  output wire o_tick
);
`include "ebt_consts.vh"
  reg [`EBT_PRE_W-1:0] cnt_reg;
  wire [`EBT_PRE_W-1:0] cnt_next;
  assign cnt_next = cnt_reg + `EBT_PRE_ONE;
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_reg <= `EBT_PRE_ZERO;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  // divide by 2^k ticks when the low k bits all carry together
  function carry_at;
    input [`EBT_PRE_W-1:0] c;
    input [2:0] s;
    begin
      case (s)
        3'h0: carry_at = &c[12:0];
        3'h1: carry_at = &c[10:0];
        3'h2: carry_at = &c[8:0];
        3'h3: carry_at = &c[7:0];
        3'h4: carry_at = &c[5:0];
        3'h5: carry_at = &c[3:0];
        3'h6: carry_at = &c[1:0];
        default: carry_at = 1'b0;
      endcase
    end
  endfunction
  assign o_tick = carry_at(cnt_reg, i_sel);
endmodule

/* File: src/ebt_timer.v */
// eight-bit interval and auto-reload timer with register port
// Behaviour
// - mode bit selects interval or auto-reload
// - codes 0-6 pick seven prescaled clocks
// - code 7 counts selected event pin edges
// - mode bits 6..3 always read ones
// - counter increments per count pulse and is loaded by reload writes
// - every overflow sets the overflow flag
// - counter reads and reload writes share address
// - counter resets to zero
// - reload write also loads counter immediately
// - auto-reload overflow loads reload value
// - reload period spans 1 to 256 pulses
// - reload register resets to zero
// - interval mode wraps to zero on overflow
// - flag and enable request interrupt
module ebt_timer (
  // clock and reset
  input wire i_clk_sys,
  input wire i_nrst,
  // register port
  input wire [1:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // event pin
  input wire i_event_input_pin,
  // interrupt request
  output wire o_irq
);
`include "ebt_consts.vh"
  reg [7:0] mode_reg;
  reg [7:0] count_reg;
  reg [7:0] count_next;
  reg [7:0] reload_reg;
  reg flag_reg;
  reg flag_next;
  reg irq_en_reg;
  reg edge_sel_reg;
  reg port_func_reg;
  reg sync1_reg;
  reg sync2_reg;
  reg sync3_reg;
  reg [7:0] rdata_next;
  wire [2:0] cks;
  wire pre_tick;
  wire ext_edge;
  wire pulse;
  wire ovf;
  wire wr_mode;
  wire wr_count;
  wire wr_irq;
  wire wr_port;

  function is_addr;
    input [1:0] a;
    input [1:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  assign wr_mode = i_wr & is_addr(i_addr, `EBT_ADDR_MODE);
  assign wr_count = i_wr & is_addr(i_addr, `EBT_ADDR_COUNT);
  assign wr_irq = i_wr & is_addr(i_addr, `EBT_ADDR_IRQ);
  assign wr_port = i_wr & is_addr(i_addr, `EBT_ADDR_PORT);
  assign cks = mode_reg[`EBT_CKS_HI:`EBT_CKS_LO];

  ebt_prescaler u_pre (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_sel(cks),
    .o_tick(pre_tick)
  );

  // sync1 feeds only sync2; edge logic looks at later stages
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= i_event_input_pin;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end
  // edge select 1 counts rising edges, 0 falling
  assign ext_edge = edge_sel_reg ? (sync2_reg & ~sync3_reg) : (~sync2_reg & sync3_reg);
  // the pin function bit is not required to gate counting; software keeps to it
  assign pulse = (cks == `EBT_CKS_EXT) ? ext_edge : pre_tick;
  assign ovf = pulse & (count_reg == `EBT_COUNT_MAX);

  always @* begin
    count_next = count_reg;
    if (wr_count) begin
      count_next = i_wdata;
    end else if (ovf) begin
      if (mode_reg[`EBT_MODE_BIT]) begin
        count_next = reload_reg;
      end else begin
        count_next = `EBT_COUNT_RST;
      end
    end else if (pulse) begin
      count_next = count_reg + 8'h01;
    end
  end

  // set wins over a software clear in the same cycle
  always @* begin
    flag_next = flag_reg;
    if (wr_irq && !i_wdata[`EBT_IRQ_FLAG_BIT]) begin
      flag_next = 1'b0;
    end
    if (ovf) begin
      flag_next = 1'b1;
    end
  end

  always @* begin
    rdata_next = `EBT_BYTE_ZERO;
    case (i_addr)
      `EBT_ADDR_MODE: begin
        rdata_next = mode_reg | `EBT_RSVD_ONES;
      end
      `EBT_ADDR_COUNT: begin
        rdata_next = count_reg;
      end
      `EBT_ADDR_IRQ: begin
        rdata_next[`EBT_IRQ_FLAG_BIT] = flag_reg;
        rdata_next[`EBT_IRQ_EN_BIT] = irq_en_reg;
        rdata_next[`EBT_IRQ_EDGE_BIT] = edge_sel_reg;
      end
      `EBT_ADDR_PORT: begin
        rdata_next[`EBT_PORT_FUNC_BIT] = port_func_reg;
      end
      default: begin
        rdata_next = `EBT_BYTE_ZERO;
      end
    endcase
  end

  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_reg <= `EBT_MODE_RST;
      count_reg <= `EBT_COUNT_RST;
      reload_reg <= `EBT_RELOAD_RST;
      flag_reg <= 1'b0;
      irq_en_reg <= 1'b0;
      edge_sel_reg <= 1'b0;
      port_func_reg <= 1'b0;
      o_rdata <= `EBT_BYTE_ZERO;
    end else begin
      count_reg <= count_next;
      flag_reg <= flag_next;
      if (wr_mode) begin
        // reserved bits are not stored
        mode_reg <= i_wdata & ~`EBT_RSVD_ONES;
      end
      if (wr_count) begin
        reload_reg <= i_wdata;
      end
      if (wr_irq) begin
        irq_en_reg <= i_wdata[`EBT_IRQ_EN_BIT];
        edge_sel_reg <= i_wdata[`EBT_IRQ_EDGE_BIT];
      end
      if (wr_port) begin
        port_func_reg <= i_wdata[`EBT_PORT_FUNC_BIT];
      end
      if (i_rd) begin
        o_rdata <= rdata_next;
      end else begin
        o_rdata <= `EBT_BYTE_ZERO;
      end
    end
  end

  assign o_irq = flag_reg & irq_en_reg;
endmodule

/* File: tb/ebt_event_src.sv */
// external event pin source
module ebt_event_src (
  input logic i_clk_sys,
  output logic o_pin
);
  timeunit 1ns / 1ps;
  initial o_pin = 1'b0;
  // pulses are wide so the two-flop sync never misses one
  task automatic pulse(input int n);
    repeat (n) begin
      repeat (4) @(posedge i_clk_sys);
      o_pin <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      o_pin <= 1'b0;
    end
  endtask
endmodule

/* File: tb/ebt_timer_sva.sv */
// port checks for the reload timer
module ebt_timer_sva (
  input logic i_clk_sys,
  input logic i_nrst,
  input logic [1:0] i_addr,
  input logic [7:0] i_wdata,
  input logic i_wr,
  input logic i_rd,
  input logic [7:0] o_rdata,
  input logic o_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);
  property p_idle; !i_rd |=> o_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_rsvd; i_rd && i_addr == 2'h0 |=> o_rdata[6:3] == 4'hF; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not ones");
  property p_mode; i_wr && i_addr == 2'h0 ##1 i_rd && i_addr == 2'h0 |=> o_rdata == ($past(i_wdata, 2) | 8'h78); endproperty
  a_mode: assert property (p_mode) else $error("mode readback wrong");
  property p_load; i_wr && i_addr == 2'h1 ##1 i_rd && i_addr == 2'h1 |=> o_rdata == $past(i_wdata, 2); endproperty
  a_load: assert property (p_load) else $error("reload not loaded");
  property p_port; i_wr && i_addr == 2'h3 ##1 i_rd && i_addr == 2'h3 |=> o_rdata[0] == $past(i_wdata[0], 2); endproperty
  a_port: assert property (p_port) else $error("pin function lost");
  property p_off; i_wr && i_addr == 2'h2 && !i_wdata[1] |=> !o_irq; endproperty
  a_off: assert property (p_off) else $error("irq without enable");
  property p_hold; o_irq && !(i_wr && i_addr == 2'h2) |=> o_irq; endproperty
  a_hold: assert property (p_hold) else $error("irq dropped alone");
  property p_irqrd; i_rd && i_addr == 2'h2 && o_irq |=> o_rdata[1:0] == 2'h3; endproperty
  a_irqrd: assert property (p_irqrd) else $error("flag read wrong");
  c_load: cover property (i_wr && i_addr == 2'h1);
  c_irq: cover property ($rose(o_irq));
  c_mode: cover property (i_rd && i_addr == 2'h0);
endmodule
bind ebt_timer ebt_timer_sva u_sva (
  .i_clk_sys(i_clk_sys),
  .i_nrst(i_nrst),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .o_rdata(o_rdata),
  .o_irq(o_irq)
);

/* File: tb/testbench.sv */
// self-checking bench for the reload timer
module testbench;
  timeunit 1ns / 1ps;
  logic i_clk_sys = 1'b0;
  logic i_nrst = 1'b0;
  logic [1:0] i_addr = 2'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic o_irq;
  logic pin;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  // divide ratios of clock select codes 0 to 5
  int div_tbl[6] = '{8192, 2048, 512, 256, 64, 16};
  ebt_event_src u_src (.i_clk_sys(i_clk_sys), .o_pin(pin));
  ebt_timer u_dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_event_input_pin(pin), .o_irq(o_irq));
  initial begin
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // interrupt line is looked at mid-cycle, away from the edge that moves it
  task automatic chk_irq(input logic exp);
    @(negedge i_clk_sys);
    samples_checked++;
    if (o_irq !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, o_irq, exp);
    end
    @(posedge i_clk_sys);
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
  endtask
  // masked read lets one compare cover a small range of counts
  task automatic rd(input logic [1:0] a, input logic [7:0] m, input logic [7:0] exp);
    i_addr <= a;
    i_rd <= 1'b1;
    i_wr <= 1'b0;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(negedge i_clk_sys);
    chk(o_rdata & m, exp);
    @(posedge i_clk_sys);
  endtask
  task automatic idle(input int n);
    i_wr <= 1'b0;
    repeat (n) @(posedge i_clk_sys);
  endtask
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (4) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    @(posedge i_clk_sys);
    rd(2'h0, 8'hFF, 8'h78);
    rd(2'h1, 8'hFF, 8'h00);
    wr(2'h0, 8'h85);
    rd(2'h0, 8'hFF, 8'hFD);
    wr(2'h0, 8'h86);
    wr(2'h2, 8'h06);
    wr(2'h1, 8'hFE);
    rd(2'h1, 8'hFF, 8'hFE);
    idle(12);
    rd(2'h1, 8'hFE, 8'hFE);
    rd(2'h2, 8'h03, 8'h03);
    chk_irq(1'b1);
    wr(2'h2, 8'h00);
    rd(2'h2, 8'h02, 8'h00);
    chk_irq(1'b0);
    wr(2'h0, 8'h06);
    wr(2'h1, 8'hFE);
    idle(16);
    rd(2'h1, 8'hF8, 8'h00);
    wr(2'h3, 8'h01);
    rd(2'h3, 8'h01, 8'h01);
    wr(2'h0, 8'h07);
    wr(2'h2, 8'h04);
    wr(2'h1, 8'h10);
    idle(1);
    u_src.pulse(5);
    idle(4);
    rd(2'h1, 8'hFF, 8'h15);
    wr(2'h2, 8'h00);
    wr(2'h1, 8'h10);
    idle(1);
    u_src.pulse(3);
    idle(4);
    rd(2'h1, 8'hFF, 8'h13);
    // a window of two periods holds exactly two ticks whatever the prescaler phase
    for (int k = 0; k < 6; k++) begin
      wr(2'h0, 8'(k));
      wr(2'h1, 8'h00);
      idle(2 * div_tbl[k]);
      rd(2'h1, 8'hFF, 8'h02);
    end
    tally_and_finish();
  end
endmodule
